// *** hdl/hwm_pkg.sv ***
/*
 * Constants and types of the hardware-monitor host access block.
 * Assumes one 125 MHz clock shared with the host I/O decoder.
 */
package hwm_pkg;
    localparam int CLK_HZ        = 125_000_000;
    localparam int TACH_HZ       = 22_500;
    localparam int BEEP_HZ       = 2_000;
    localparam int TACH_DIV_DEF  = CLK_HZ / TACH_HZ;
    localparam int BEEP_HALF_DEF = CLK_HZ / (2 * BEEP_HZ);

    localparam logic [15:0] IO_BASE    = 16'h0290;
    localparam logic [2:0]  PORT_INDEX = 3'h5;
    localparam logic [2:0]  PORT_DATA  = 3'h6;

    localparam int ADC_STEP_MV = 16;
    localparam int ADC_BITS    = 8;
    localparam int ADC_FSR_MV  = ADC_STEP_MV * (2 ** ADC_BITS);
    localparam int VCC_MV      = 5000;
    localparam int VCC_RTOP_K  = 34;
    localparam int VCC_RBOT_K  = 50;
    // Code of the divided +5 V rail, about 2.98 V.
    localparam logic [7:0] VCC_EXPECT_CODE = 8'(VCC_MV * VCC_RBOT_K /
        (VCC_RTOP_K + VCC_RBOT_K) / ADC_STEP_MV);

    localparam int NVOLT = 7;
    localparam int NFAN  = 2;
    localparam int NSTAT = 12;
    localparam logic [3:0] CH_VCC   = 4'h3;
    localparam logic [3:0] CH_TEMP1 = 4'h7;
    localparam logic [3:0] CH_TEMP2 = 4'h8;
    localparam logic [3:0] CH_LAST  = 4'h8;

    localparam logic [7:0] REG_VOLT_BASE = 8'h20;
    localparam logic [7:0] REG_VOLT_LAST = 8'h26;
    localparam logic [7:0] REG_TEMP2     = 8'h27;
    localparam logic [7:0] REG_FAN0      = 8'h28;
    localparam logic [7:0] REG_FAN1      = 8'h29;
    localparam logic [7:0] REG_VLIM_BASE = 8'h2b;
    localparam logic [7:0] REG_VLIM_LAST = 8'h38;
    localparam logic [7:0] REG_T2_HIGH   = 8'h39;
    localparam logic [7:0] REG_T2_HYST   = 8'h3a;
    localparam logic [7:0] REG_FLIM0     = 8'h3b;
    localparam logic [7:0] REG_FLIM1     = 8'h3c;
    localparam logic [7:0] REG_CONFIG    = 8'h40;
    localparam logic [7:0] REG_STAT_LO   = 8'h41;
    localparam logic [7:0] REG_STAT_HI   = 8'h42;
    localparam logic [7:0] REG_MASK_LO   = 8'h43;
    localparam logic [7:0] REG_MASK_HI   = 8'h44;
    localparam logic [7:0] REG_BANK      = 8'h4e;
    localparam logic [7:0] REG_T1_UPPER  = 8'h50;
    localparam logic [7:0] REG_T1_LSB    = 8'h51;
    localparam logic [7:0] REG_T1_HIGH   = 8'h53;
    localparam logic [7:0] REG_BEEP_EN   = 8'h56;
    localparam logic [7:0] REG_DUTY0     = 8'h5a;
    localparam logic [7:0] REG_DUTY1     = 8'h5b;

    localparam logic [7:0] RST_VHIGH  = 8'hff;
    localparam logic [7:0] RST_VLOW   = 8'h00;
    localparam logic [7:0] RST_T2HIGH = 8'h50;
    localparam logic [7:0] RST_T2HYST = 8'h4b;
    localparam logic [7:0] RST_T1HIGH = 8'h50;
    localparam logic [7:0] RST_FLIM   = 8'hff;
    localparam logic [7:0] RST_CONFIG = 8'h01;
    localparam logic [7:0] RST_DUTY   = 8'hff;
    localparam logic [7:0] PWM_TOP    = 8'hfe;
    localparam logic [7:0] FAN_SAT    = 8'hff;
    localparam int CFG_START = 0;

    localparam int ST_TEMP2 = 7;
    localparam int ST_FAN0  = 8;
    localparam int ST_TEMP1 = 10;
    localparam int ST_CASE  = 11;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} hwm_seq_state_t;
endpackage : hwm_pkg

// *** hdl/hwm_adc_if.sv ***
/*
 * Link from the converter sequencer to the register logic.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/10ps
`default_nettype none
interface hwm_adc_if;
    logic       enable;
    logic       resultValid;
    logic [3:0] resultChan;
    logic [7:0] resultCode;
    logic       resultHalf;

    modport seq  (input enable, output resultValid, resultChan, resultCode,
                  resultHalf);
    modport user (output enable, input resultValid, resultChan, resultCode,
                  resultHalf);
endinterface : hwm_adc_if
`default_nettype wire

// *** hdl/hwm_conv_seq.sv ***
/*
 * Sequencer of the one shared converter: steps the channel, pulses start.
 * Assumes done and code are asynchronous, code stable before done rises.
 */
`timescale 1ns/10ps
`default_nettype none
module hwm_conv_seq
    import hwm_pkg::*;
(
    input  wire logic   mclk,
    input  wire logic   rst,
    hwm_adc_if.seq      adc,
    output logic        adcStart,
    output logic [3:0]  adcChan,
    input  wire logic   adcDone,
    input  wire logic [7:0] adcCode,
    input  wire logic   adcHalf
);
    typedef struct packed {
        hwm_seq_state_t state;
        logic [3:0]     chan;
        logic           start;
        logic           doneS1;
        logic           doneS2;
        logic           donePrev;
        logic [7:0]     codeS1;
        logic [7:0]     codeS2;
        logic           halfS1;
        logic           halfS2;
        logic           valid;
        logic [3:0]     resChan;
        logic [7:0]     resCode;
        logic           resHalf;
    } hwm_seq_t;

    hwm_seq_t s_q;
    hwm_seq_t s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.doneS1 = adcDone;
        s_d.doneS2 = s_q.doneS1;
        s_d.donePrev = s_q.doneS2;
        s_d.codeS1 = adcCode;
        s_d.codeS2 = s_q.codeS1;
        s_d.halfS1 = adcHalf;
        s_d.halfS2 = s_q.halfS1;
        s_d.valid = 1'b0;
        s_d.start = 1'b0;
        case (s_q.state)
            SEQ_IDLE:
            begin
                if (adc.enable)
                begin
                    s_d.start = 1'b1;
                    s_d.state = SEQ_START;
                end
            end
            SEQ_START:
                s_d.state = SEQ_WAIT;
            SEQ_WAIT:
            begin
                // One converter, one channel at a time. [RQ3] [RQ4]
                if (s_q.doneS2 && !s_q.donePrev)
                begin
                    s_d.valid = 1'b1;
                    s_d.resChan = s_q.chan;
                    s_d.resCode = s_q.codeS2;
                    s_d.resHalf = s_q.halfS2;
                    s_d.chan = (s_q.chan == CH_LAST) ? 4'h0 : s_q.chan + 4'h1;
                    s_d.state = SEQ_IDLE;
                end
            end
            default:
                s_d.state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign adcStart = s_q.start;
    assign adcChan = s_q.chan;
    assign adc.resultValid = s_q.valid;
    assign adc.resultChan = s_q.resChan;
    assign adc.resultCode = s_q.resCode;
    assign adc.resultHalf = s_q.resHalf;
endmodule : hwm_conv_seq
`default_nettype wire

// *** hdl/hwm_host_access.sv ***
/*
 * Hardware-monitor core: index/data port, result registers, alarms, pins.
 * Assumes one-cycle I/O strobes on mclk; tach, intrusion, converter async.
 */
// Function
// RQ1 - Index port 295h selects, data port 296h accesses.
// RQ2 - Only address bits 2..0 differ; base fixed.
// RQ3 - One shared 8-bit converter, 16 mV step.
// RQ4 - Seven voltages, two fans, two temps, intrusion readable.
// RQ5 - Temp two 8-bit, temp one 9-bit two's-complement.
// RQ6 - Register 27h returns full temperature two.
// RQ7 - Bank one 50h upper bits, 51h bit 7 LSB.
// RQ8 - Programmable limits raise one maskable interrupt, beep.
// RQ9 - Two PWM outputs, beep, interrupt, overtemp, alert.
// RQ10 - Internal 34K/50K divider monitors +5 V rail.
// RQ11 - Data accesses use last index until rewritten.
`timescale 1ns/10ps
`default_nettype none
module hwm_host_access
#(
    parameter int TACH_DIV  = hwm_pkg::TACH_DIV_DEF,
    parameter int BEEP_HALF = hwm_pkg::BEEP_HALF_DEF
)
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioWrStb,
    input  wire logic        ioRdStb,
    input  wire logic [7:0]  ioWrData,
    output logic [7:0]       ioRdData,
    output logic             ioRdValid,
    output logic             adcStart,
    output logic [3:0]       adcChan,
    input  wire logic        adcDone,
    input  wire logic [7:0]  adcCode,
    input  wire logic        adcHalf,
    input  wire logic [1:0]  fanTach,
    input  wire logic        chassisIntrusionInN,
    output logic [1:0]       fanPwm,
    output logic             beepTone,
    output logic             systemManagementInterrupt,
    output logic             overTemperatureOutN,
    output logic             generalAlertOutN
);
    import hwm_pkg::*;

    typedef struct packed {
        logic [7:0]             index;
        logic                   bank;
        logic [7:0]             rdData;
        logic                   rdValid;
        logic [NVOLT-1:0][7:0]  volt;
        logic [7:0]             temp2;
        logic [8:0]             temp1;
        logic [NFAN-1:0][7:0]   fan;
        logic [NVOLT-1:0][7:0]  vHigh;
        logic [NVOLT-1:0][7:0]  vLow;
        logic [7:0]             t2High;
        logic [7:0]             t2Hyst;
        logic [7:0]             t1High;
        logic [NFAN-1:0][7:0]   fanLim;
        logic [7:0]             cfg;
        logic [NSTAT-1:0]       status;
        logic [NSTAT-1:0]       mask;
        logic                   beepEn;
        logic [NFAN-1:0][7:0]   duty;
        logic [7:0]             pwmCnt;
        logic [NFAN-1:0]        pwm;
        logic [NFAN-1:0]        tachS1;
        logic [NFAN-1:0]        tachS2;
        logic [NFAN-1:0]        tachPrev;
        logic [15:0]            tachTick;
        logic [NFAN-1:0][7:0]   tachCnt;
        logic                   caseS1;
        logic                   caseS2;
        logic [15:0]            beepDiv;
        logic                   beep;
        logic                   smi;
        logic                   ovtN;
        logic                   alertN;
    } hwm_main_t;

    hwm_main_t s_q;
    hwm_main_t s_d;

    hwm_adc_if adc ();

    hwm_conv_seq u_seq (
        .mclk     (mclk),
        .rst      (rst),
        .adc      (adc.seq),
        .adcStart (adcStart),
        .adcChan  (adcChan),
        .adcDone  (adcDone),
        .adcCode  (adcCode),
        .adcHalf  (adcHalf)
    );

    assign adc.enable = s_q.cfg[CFG_START];

    logic             portHit;
    logic [7:0]       vOff;
    logic [7:0]       lOff;
    logic             inVolt;
    logic             inVlim;
    logic [7:0]       rdMux;
    logic [NVOLT-1:0] voltEvt;
    logic [NFAN-1:0]  tachFall;
    logic             tachTickNow;

    // Upper bits are the fixed base. [RQ2]
    assign portHit = (ioAddr[15:3] == IO_BASE[15:3]) &&
                     (ioAddr[2:0] == PORT_INDEX || ioAddr[2:0] == PORT_DATA);
    assign vOff = s_q.index - REG_VOLT_BASE;
    assign lOff = s_q.index - REG_VLIM_BASE;
    assign inVolt = s_q.index >= REG_VOLT_BASE && s_q.index <= REG_VOLT_LAST;
    assign inVlim = s_q.index >= REG_VLIM_BASE && s_q.index <= REG_VLIM_LAST;
    assign tachTickNow = s_q.tachTick == 16'(TACH_DIV - 1);

    for (genvar i = 0; i < NVOLT; i++)
    begin : g_volt
        // Out-of-window reading sets the alarm.
        assign voltEvt[i] = adc.resultValid && adc.resultChan == 4'(i) &&
            (adc.resultCode > s_q.vHigh[i] || adc.resultCode < s_q.vLow[i]);
    end

    for (genvar f = 0; f < NFAN; f++)
    begin : g_fan
        assign tachFall[f] = s_q.tachPrev[f] && !s_q.tachS2[f];
    end

    always_comb
    begin
        rdMux = 8'h00;
        if (s_q.index == REG_BANK)
            rdMux = {7'h00, s_q.bank};
        else if (!s_q.bank)
        begin
            if (inVolt)
                rdMux = s_q.volt[vOff[2:0]];
            else if (inVlim)
                rdMux = lOff[0] ? s_q.vLow[lOff[3:1]] : s_q.vHigh[lOff[3:1]];
            else
            begin
                case (s_q.index)
                    REG_TEMP2:   rdMux = s_q.temp2; // [RQ6]
                    REG_FAN0:    rdMux = s_q.fan[0];
                    REG_FAN1:    rdMux = s_q.fan[1];
                    REG_T2_HIGH: rdMux = s_q.t2High;
                    REG_T2_HYST: rdMux = s_q.t2Hyst;
                    REG_FLIM0:   rdMux = s_q.fanLim[0];
                    REG_FLIM1:   rdMux = s_q.fanLim[1];
                    REG_CONFIG:  rdMux = s_q.cfg;
                    REG_STAT_LO: rdMux = s_q.status[7:0];
                    REG_STAT_HI: rdMux = {4'h0, s_q.status[11:8]};
                    REG_MASK_LO: rdMux = s_q.mask[7:0];
                    REG_MASK_HI: rdMux = {4'h0, s_q.mask[11:8]};
                    REG_BEEP_EN: rdMux = {7'h00, s_q.beepEn};
                    REG_DUTY0:   rdMux = s_q.duty[0];
                    REG_DUTY1:   rdMux = s_q.duty[1];
                    default:     rdMux = 8'h00;
                endcase
            end
        end
        else
        begin
            case (s_q.index)
                REG_T1_UPPER: rdMux = s_q.temp1[8:1]; // [RQ7]
                REG_T1_LSB:   rdMux = {s_q.temp1[0], 7'h00}; // [RQ7]
                REG_T1_HIGH:  rdMux = s_q.t1High;
                default:      rdMux = 8'h00;
            endcase
        end
    end

    always_comb
    begin
        logic [NSTAT-1:0] evt;
        logic [NSTAT-1:0] clr;
        evt = '0;
        clr = '0;
        s_d = s_q;
        s_d.rdValid = 1'b0;
        s_d.tachS1 = fanTach;
        s_d.tachS2 = s_q.tachS1;
        s_d.tachPrev = s_q.tachS2;
        s_d.caseS1 = chassisIntrusionInN;
        s_d.caseS2 = s_q.caseS1;

        if (portHit && ioWrStb)
        begin
            if (ioAddr[2:0] == PORT_INDEX)
                s_d.index = ioWrData; // [RQ1] [RQ11]
            else if (s_q.index == REG_BANK)
                s_d.bank = ioWrData[0];
            else if (!s_q.bank)
            begin
                // Alarm windows. [RQ8]
                if (inVlim && lOff[0])
                    s_d.vLow[lOff[3:1]] = ioWrData;
                else if (inVlim)
                    s_d.vHigh[lOff[3:1]] = ioWrData;
                else
                begin
                    case (s_q.index)
                        REG_T2_HIGH: s_d.t2High = ioWrData;
                        REG_T2_HYST: s_d.t2Hyst = ioWrData;
                        REG_FLIM0:   s_d.fanLim[0] = ioWrData;
                        REG_FLIM1:   s_d.fanLim[1] = ioWrData;
                        REG_CONFIG:  s_d.cfg = ioWrData;
                        REG_MASK_LO: s_d.mask[7:0] = ioWrData;
                        REG_MASK_HI: s_d.mask[11:8] = ioWrData[3:0];
                        REG_BEEP_EN: s_d.beepEn = ioWrData[0];
                        REG_DUTY0:   s_d.duty[0] = ioWrData;
                        REG_DUTY1:   s_d.duty[1] = ioWrData;
                        default:     ;
                    endcase
                end
            end
            else if (s_q.index == REG_T1_HIGH)
                s_d.t1High = ioWrData;
        end

        if (portHit && ioRdStb)
        begin
            s_d.rdValid = 1'b1;
            if (ioAddr[2:0] == PORT_INDEX)
                s_d.rdData = s_q.index;
            else
            begin
                s_d.rdData = rdMux; // [RQ1] [RQ11]
                // A status read clears the bits returned.
                if (!s_q.bank && s_q.index == REG_STAT_LO)
                    clr[7:0] = '1;
                if (!s_q.bank && s_q.index == REG_STAT_HI)
                    clr[11:8] = '1;
            end
        end

        if (adc.resultValid)
        begin
            if (adc.resultChan < 4'(NVOLT))
                // Channel CH_VCC carries the divided +5 V rail. [RQ10]
                s_d.volt[adc.resultChan[2:0]] = adc.resultCode; // [RQ4]
            else if (adc.resultChan == CH_TEMP2)
            begin
                s_d.temp2 = adc.resultCode; // [RQ5]
                evt[ST_TEMP2] = $signed(adc.resultCode) > $signed(s_q.t2High);
                if ($signed(adc.resultCode) >= $signed(s_q.t2High))
                    s_d.ovtN = 1'b0; // [RQ9]
                else if ($signed(adc.resultCode) < $signed(s_q.t2Hyst))
                    s_d.ovtN = 1'b1; // [RQ9]
            end
            else if (adc.resultChan == CH_TEMP1)
            begin
                s_d.temp1 = {adc.resultCode, adc.resultHalf}; // [RQ5]
                evt[ST_TEMP1] = $signed(adc.resultCode) > $signed(s_q.t1High);
            end
        end
        evt[NVOLT-1:0] = voltEvt;

        s_d.tachTick = tachTickNow ? 16'h0000 : s_q.tachTick + 16'h0001;
        for (int f = 0; f < NFAN; f++)
        begin
            if (tachFall[f])
            begin
                s_d.fan[f] = s_q.tachCnt[f];
                s_d.tachCnt[f] = 8'h00;
                evt[ST_FAN0 + f] = s_q.tachCnt[f] > s_q.fanLim[f];
            end
            else if (tachTickNow && s_q.tachCnt[f] != FAN_SAT)
                s_d.tachCnt[f] = s_q.tachCnt[f] + 8'h01;
            else if (tachTickNow)
                s_d.fan[f] = FAN_SAT;
        end
        evt[ST_CASE] = !s_q.caseS2; // [RQ4]

        // Set wins over clear. [RQ8]
        s_d.status = (s_q.status & ~clr) | evt;
        s_d.smi = |(s_d.status & ~s_q.mask); // [RQ8] [RQ9]
        s_d.alertN = ~|s_d.status; // [RQ9]

        s_d.pwmCnt = (s_q.pwmCnt == PWM_TOP) ? 8'h00 : s_q.pwmCnt + 8'h01;
        for (int f = 0; f < NFAN; f++)
            s_d.pwm[f] = s_q.pwmCnt < s_q.duty[f]; // [RQ9]

        if (s_q.beepEn && s_q.smi)
        begin
            // Tone while an unmasked alarm stands. [RQ8] [RQ9]
            if (s_q.beepDiv == 16'(BEEP_HALF - 1))
            begin
                s_d.beepDiv = 16'h0000;
                s_d.beep = !s_q.beep;
            end
            else
                s_d.beepDiv = s_q.beepDiv + 16'h0001;
        end
        else
        begin
            s_d.beepDiv = 16'h0000;
            s_d.beep = 1'b0;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            s_q <= '0;
            s_q.vHigh <= {NVOLT{RST_VHIGH}};
            s_q.vLow <= {NVOLT{RST_VLOW}};
            s_q.t2High <= RST_T2HIGH;
            s_q.t2Hyst <= RST_T2HYST;
            s_q.t1High <= RST_T1HIGH;
            s_q.fanLim <= {NFAN{RST_FLIM}};
            s_q.cfg <= RST_CONFIG;
            s_q.duty <= {NFAN{RST_DUTY}};
            s_q.tachS1 <= '1;
            s_q.tachS2 <= '1;
            s_q.tachPrev <= '1;
            s_q.caseS1 <= 1'b1;
            s_q.caseS2 <= 1'b1;
            s_q.ovtN <= 1'b1;
            s_q.alertN <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign ioRdData = s_q.rdData;
    assign ioRdValid = s_q.rdValid;
    assign fanPwm = s_q.pwm;
    assign beepTone = s_q.beep;
    assign systemManagementInterrupt = s_q.smi;
    assign overTemperatureOutN = s_q.ovtN;
    assign generalAlertOutN = s_q.alertN;
endmodule : hwm_host_access
`default_nettype wire

// *** testbench/hwm_host_access_props.sv ***
/*
 * Checks on the host access block's ports.
 * Assumes it is bound to the block top.
 */
`timescale 1ns/10ps
`default_nettype none
module hwm_host_access_props
    import hwm_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [15:0] ioAddr,
    input wire logic        ioRdStb,
    input wire logic        ioRdValid,
    input wire logic [7:0]  ioRdData,
    input wire logic        adcStart,
    input wire logic [3:0]  adcChan,
    input wire logic        chassisIntrusionInN,
    input wire logic        generalAlertOutN,
    input wire logic        beepTone,
    input wire logic        systemManagementInterrupt
);
    logic [3:0] lastChan_q;
    logic       portRd;

    assign portRd = ioRdStb && ioAddr[15:3] == IO_BASE[15:3] &&
        (ioAddr[2:0] == PORT_INDEX || ioAddr[2:0] == PORT_DATA);

    always_ff @(posedge mclk)
    begin
        if (rst)
            lastChan_q <= CH_LAST;
        else if (adcStart)
            lastChan_q <= adcChan;
    end

    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_portRead;
        portRd;
    endsequence
    sequence s_holdChan;
        adcStart ##1 $stable(adcChan) [*4];
    endsequence

    property p_readAnswer;
        s_portRead |=> ioRdValid;
    endproperty
    property p_noStrayAnswer;
        !portRd |=> !ioRdValid;
    endproperty
    property p_dataHolds;
        !ioRdValid |-> $stable(ioRdData);
    endproperty
    property p_startPulse;
        adcStart |=> !adcStart;
    endproperty
    property p_chanRange;
        adcStart |-> adcChan <= CH_LAST;
    endproperty
    property p_chanStable;
        adcStart |-> s_holdChan;
    endproperty
    property p_roundRobin;
        adcStart |->
            adcChan == ((lastChan_q == CH_LAST) ? 4'h0 : lastChan_q + 4'h1);
    endproperty
    property p_intrusionAlert;
        (!chassisIntrusionInN) [*8] |-> !generalAlertOutN;
    endproperty
    property p_beepNeedsAlarm;
        $rose(beepTone) |->
            systemManagementInterrupt || $past(systemManagementInterrupt);
    endproperty

    a_readAnswer: assert property (p_readAnswer)
        else $error("port read not answered");
    a_noStrayAnswer: assert property (p_noStrayAnswer)
        else $error("answer without a read");
    a_dataHolds: assert property (p_dataHolds)
        else $error("read data moved");
    a_startPulse: assert property (p_startPulse)
        else $error("start too long");
    a_chanRange: assert property (p_chanRange)
        else $error("channel out of range");
    a_chanStable: assert property (p_chanStable)
        else $error("channel moved in conversion");
    a_roundRobin: assert property (p_roundRobin)
        else $error("channel order broken");
    a_intrusionAlert: assert property (p_intrusionAlert)
        else $error("intrusion not alerted");
    a_beepNeedsAlarm: assert property (p_beepNeedsAlarm)
        else $error("beep without alarm");
endmodule : hwm_host_access_props

bind hwm_host_access hwm_host_access_props u_props (.mclk(mclk), .rst(rst),
    .ioAddr(ioAddr), .ioRdStb(ioRdStb), .ioRdValid(ioRdValid),
    .ioRdData(ioRdData), .adcStart(adcStart), .adcChan(adcChan),
    .chassisIntrusionInN(chassisIntrusionInN), .beepTone(beepTone),
    .generalAlertOutN(generalAlertOutN),
    .systemManagementInterrupt(systemManagementInterrupt));
`default_nettype wire

// *** testbench/hwm_adc_model.sv ***
/*
 * Converter model: answers each start, fast and slow in turn, with the
 * code set for that channel. Assumes start and channel change on posedge.
 */
`timescale 1ns/10ps
`default_nettype none
module hwm_adc_model
(
    input  wire logic       mclk,
    input  wire logic       adcStart,
    input  wire logic [3:0] adcChan,
    input  wire logic [7:0] chanCode [9],
    input  wire logic       halfBit,
    output logic            adcDone,
    output logic [7:0]      adcCode,
    output logic            adcHalf
);
    logic [3:0] ch;
    logic       slow;

    initial
    begin
        adcDone = 1'b0;
        adcCode = 8'h5a;
        adcHalf = 1'b0;
        slow    = 1'b0;
        forever
        begin
            @(negedge mclk);
            if (adcStart === 1'b1)
            begin
                ch = adcChan;
                repeat (slow ? 12 : 5) @(negedge mclk);
                adcCode = chanCode[ch];
                adcHalf = halfBit;
                @(negedge mclk);
                adcDone = 1'b1;
                repeat (3) @(negedge mclk);
                adcDone = 1'b0;
                // Code is not held once done falls.
                adcCode = ~chanCode[ch];
                adcHalf = ~halfBit;
                slow    = !slow;
            end
        end
    end
endmodule : hwm_adc_model
`default_nettype wire

// *** testbench/hwm_host_access_tb.sv ***
/*
 * Bench of the host access block as host.
 * Assumes the converter model beside it.
 */
`timescale 1ns/10ps
`default_nettype none
module hwm_host_access_tb;
    import hwm_pkg::*;
    logic mclk = 0, rst = 1, ioWrStb = 0, ioRdStb = 0, halfBit = 0;
    logic [15:0] ioAddr = 0;
    logic [7:0]  ioWrData = 0, ioRdData, adcCode;
    logic        ioRdValid, adcStart, adcDone, adcHalf, beepTone, smi, b;
    logic        ovtN, alertN, chassisIntrusionInN = 1;
    logic [3:0]  adcChan;
    logic [1:0]  fanTach = '1, fanPwm;
    logic [7:0]  chanCode [9];
    logic [15:0] expQ [$];
    logic [15:0] e;
    int mismatches = 0, cmp_count = 0;

    always #4 mclk = ~mclk;
    always begin repeat (40) @(posedge mclk); fanTach <= fanTach + 2'd1; end

    hwm_host_access #(.TACH_DIV(8), .BEEP_HALF(4)) u_dut (
        .mclk(mclk), .rst(rst), .ioAddr(ioAddr), .ioWrStb(ioWrStb),
        .ioRdStb(ioRdStb), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .ioRdValid(ioRdValid), .adcStart(adcStart), .adcChan(adcChan),
        .adcDone(adcDone), .adcCode(adcCode), .adcHalf(adcHalf),
        .fanTach(fanTach), .chassisIntrusionInN(chassisIntrusionInN),
        .fanPwm(fanPwm), .beepTone(beepTone),
        .systemManagementInterrupt(smi), .overTemperatureOutN(ovtN),
        .generalAlertOutN(alertN));
    hwm_adc_model u_adc (.mclk(mclk), .adcStart(adcStart),
        .adcChan(adcChan), .chanCode(chanCode), .halfBit(halfBit),
        .adcDone(adcDone), .adcCode(adcCode), .adcHalf(adcHalf));

    task automatic chkRead(logic [7:0] exp, logic [7:0] m, logic [7:0] got);
        cmp_count++;
        if ((got & m) !== (exp & m))
        begin
            mismatches++;
            $display("CHECK FAILED read exp %h got %h", exp & m, got & m);
        end
    endtask : chkRead
    task automatic chkPin(string n, logic [1:0] exp, logic [1:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", n, exp, got);
        end
    endtask : chkPin
    task automatic io(logic [15:0] a, logic [7:0] d, bit rd);
        @(posedge mclk);
        ioAddr   <= a;
        ioWrData <= d;
        if (rd) ioRdStb <= 1'b1; else ioWrStb <= 1'b1;
        @(posedge mclk);
        ioRdStb <= 1'b0;
        ioWrStb <= 1'b0;
    endtask : io
    task automatic rdIo(logic [15:0] a, logic [7:0] exp, logic [7:0] m);
        expQ.push_back({m, exp});
        io(a, 8'h00, 1);
    endtask : rdIo
    task automatic wrReg(logic [7:0] idx, logic [7:0] d);
        io(16'h0295, idx, 0);
        io(16'h0296, d, 0);
    endtask : wrReg
    task automatic rdReg(logic [7:0] idx, logic [7:0] exp, logic [7:0] m);
        io(16'h0295, idx, 0);
        rdIo(16'h0296, exp, m);
    endtask : rdReg
    task automatic finish_test;
        if (expQ.size() != 0) mismatches++;
        if (mismatches == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : finish_test

    always @(negedge mclk)
    begin
        if (ioRdValid === 1'b1)
        begin
            if (expQ.size() == 0) chkPin("stray", 2'h0, 2'h1);
            else
            begin
                e = expQ.pop_front();
                chkRead(e[7:0], e[15:8], ioRdData);
            end
        end
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        finish_test();
    end

    initial
    begin
        void'($urandom(27));
        foreach (chanCode[i]) chanCode[i] = 8'($urandom());
        // Keep temperatures under their high limits.
        chanCode[CH_TEMP1] = chanCode[CH_TEMP1] & 8'h3f;
        chanCode[CH_TEMP2] = chanCode[CH_TEMP2] & 8'h3f;
        halfBit = 1'($urandom());
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        repeat (600) @(posedge mclk);
        for (int i = 0; i < NVOLT; i++)
            rdReg(REG_VOLT_BASE + 8'(i), chanCode[i], 8'hff);
        rdReg(REG_TEMP2, chanCode[CH_TEMP2], 8'hff);
        io(16'h0296, ~chanCode[CH_TEMP2], 0);
        rdIo(16'h0296, chanCode[CH_TEMP2], 8'hff);
        rdIo(16'h0296, chanCode[CH_TEMP2], 8'hff);
        io(16'h0395, REG_CONFIG, 0);
        io(16'h0297, 8'h00, 1);
        rdIo(16'h0296, chanCode[CH_TEMP2], 8'hff);
        wrReg(REG_BANK, 8'h01);
        rdReg(REG_T1_UPPER, chanCode[CH_TEMP1], 8'hff);
        rdReg(REG_T1_LSB, {halfBit, 7'h00}, 8'h80);
        wrReg(REG_BANK, 8'h00);
        wrReg(REG_BEEP_EN, 8'h01);
        @(posedge mclk);
        chassisIntrusionInN <= 1'b0;
        repeat (40) @(negedge mclk);
        chkPin("alert", 2'h0, {1'b0, alertN});
        chkPin("smi", 2'h1, {1'b0, smi});
        chkPin("ovt", 2'h1, {1'b0, ovtN});
        chkPin("pwm", 2'h3, fanPwm);
        b = beepTone;
        repeat (4) @(negedge mclk);
        chkPin("beep", {1'b0, !b}, {1'b0, beepTone});
        rdReg(REG_STAT_HI, 8'h08, 8'h08);
        wrReg(REG_MASK_HI, 8'h08);
        repeat (10) @(negedge mclk);
        chkPin("smi", 2'h0, {1'b0, smi});
        chkPin("alert", 2'h0, {1'b0, alertN});
        chkPin("beep", 2'h0, {1'b0, beepTone});
        repeat (10) @(posedge mclk);
        finish_test();
    end
endmodule : hwm_host_access_tb
`default_nettype wire
